// File: rtl/mtcc_ctrl.sv
/*
 Configuration and interlock controller for the modulator and
 demodulator settings, with the differential symbol coders.
 Assumes synchronous inputs on clk_sys_i, one-cycle edit and execute
 pulses from the front panel, and option straps held steady.
*/
`timescale 1ns/100ps
module mtcc_ctrl (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        edit_valid_i,
    input  wire logic [3:0]  edit_sel_i,
    input  wire logic [20:0] edit_val_i,
    input  wire logic        execute_i,
    input  wire logic        rs_opt_i,
    input  wire logic        hstab_opt_i,
    input  wire logic        rs_qualify_i,
    input  wire logic [1:0]  overhead_i,
    input  wire logic        tx_reprog_i,
    input  wire logic [20:0] tx_freq_i,
    input  wire logic [1:0]  tx_sym_i,
    input  wire logic        tx_sym_vld_i,
    input  wire logic [1:0]  rx_sym_i,
    input  wire logic        rx_sym_vld_i,
    output logic             pend_valid_o,
    output logic             reject_o,
    output logic             tx_out_off_o,
    output logic             diff_enc_en_o,
    output logic [1:0]       carrier_mode_o,
    output logic             cw_unmod_o,
    output logic             cw_supp_o,
    output logic             sb_upper_o,
    output logic             sb_lower_o,
    output logic [2:0]       sb_div_o,
    output logic [1:0]       mod_ref_sel_o,
    output logic             clock_synth_reference_select_o,
    output logic             rs_enc_en_o,
    output logic [2:0]       rx_preset_o,
    output logic [15:0]      rx_rate_kbps_o,
    output logic [1:0]       rs_dec_mode_o,
    output logic             descr_avail_o,
    output logic             descr_en_o,
    output logic             descr_sync_o,
    output logic             diff_dec_en_o,
    output logic             rf_loop_o,
    output logic             if_loop_o,
    output logic             if_in_internal_o,
    output logic [20:0]      demod_freq_o,
    output logic [1:0]       tx_sym_o,
    output logic             tx_sym_vld_o,
    output logic [1:0]       rx_sym_o,
    output logic             rx_sym_vld_o
);
    // Frequency must sit in range and on the step grid
    function automatic logic freq_ok(input logic [20:0] f);
        freq_ok = (f >= mtcc_pkg::FREQ_MIN) && (f <= mtcc_pkg::FREQ_MAX)
                  && ((f % mtcc_pkg::FREQ_STEP) == 21'h0);
    endfunction

    function automatic logic [15:0] preset_rate(input logic [2:0] p,
                                                input logic [15:0] v);
        case (p)
            mtcc_pkg::PRE_A: preset_rate = mtcc_pkg::RATE_A_KBPS;
            mtcc_pkg::PRE_B: preset_rate = mtcc_pkg::RATE_B_KBPS;
            mtcc_pkg::PRE_C: preset_rate = mtcc_pkg::RATE_C_KBPS;
            mtcc_pkg::PRE_D: preset_rate = mtcc_pkg::RATE_D_KBPS;
            default:         preset_rate = v;
        endcase
    endfunction

    logic                 pend_vld_q, pend_vld_d;
    logic [3:0]           pend_sel_q, pend_sel_d;
    logic [20:0]          pend_val_q, pend_val_d;
    logic                 rej_q, rej_d, txoff_q, txoff_d;
    logic                 denc_q, denc_d, ddec_q, ddec_d;
    mtcc_pkg::mtcc_car_e  car_q, car_d;
    logic [3:0]           cw_q, cw_d;
    logic [2:0]           div_q, div_d;
    logic [1:0]           mref_q, mref_d;
    logic                 sref_q, sref_d, rse_q, rse_d;
    mtcc_pkg::mtcc_rsd_e  rsd_q, rsd_d;
    logic [2:0]           pre_q, pre_d;
    logic [15:0]          vrate_q, vrate_d, rate_q, rate_d;
    logic                 descr_q, descr_d;
    logic [2:0]           dsc_q, dsc_d;
    mtcc_pkg::mtcc_loop_e loop_q, loop_d;
    logic [20:0]          dfreq_q, dfreq_d, save_q, save_d;
    logic                 rx_prog;
    logic                 qual;
    logic                 hide_descr;

    assign qual       = rs_opt_i && rs_qualify_i;
    assign hide_descr = (overhead_i == mtcc_pkg::OH_IBS) ||
                        (overhead_i == mtcc_pkg::OH_DI);

    // Configuration next state; an edit is only applied on execute
    always_comb begin
        pend_vld_d = pend_vld_q;
        pend_sel_d = pend_sel_q;
        pend_val_d = pend_val_q;
        rej_d   = 1'b0;
        denc_d  = denc_q;
        ddec_d  = ddec_q;
        car_d   = car_q;
        mref_d  = mref_q;
        sref_d  = sref_q;
        rse_d   = rse_q;
        rsd_d   = rsd_q;
        pre_d   = pre_q;
        vrate_d = vrate_q;
        descr_d = descr_q;
        loop_d  = loop_q;
        save_d  = save_q;
        dfreq_d = dfreq_q;
        rx_prog = 1'b0;
        if (execute_i && pend_vld_q) begin
            pend_vld_d = 1'b0;
            case (pend_sel_q)
                mtcc_pkg::SEL_DIFF_ENC: denc_d = pend_val_q[0];
                mtcc_pkg::SEL_DIFF_DEC: ddec_d = pend_val_q[0];
                mtcc_pkg::SEL_CARRIER:
                    car_d = mtcc_pkg::mtcc_car_e'(pend_val_q[1:0]);
                mtcc_pkg::SEL_MOD_REF: begin
                    if (hstab_opt_i) mref_d = pend_val_q[1:0];
                    else rej_d = 1'b1;
                end
                mtcc_pkg::SEL_SYN_REF: begin
                    if (hstab_opt_i) sref_d = pend_val_q[0];
                    else rej_d = 1'b1;
                end
                mtcc_pkg::SEL_RS_ENC: begin
                    if (pend_val_q[0] && !qual) rej_d = 1'b1;
                    else rse_d = pend_val_q[0];
                end
                mtcc_pkg::SEL_RS_DEC: begin
                    if (pend_val_q[1:0] == 2'h3) rej_d = 1'b1;
                    else if (pend_val_q[1:0] == mtcc_pkg::RSD_ON && !qual)
                        rej_d = 1'b1;
                    else rsd_d = mtcc_pkg::mtcc_rsd_e'(pend_val_q[1:0]);
                end
                mtcc_pkg::SEL_RX_PRE: begin
                    if (pend_val_q[2:0] > mtcc_pkg::PRE_V) rej_d = 1'b1;
                    else begin
                        pre_d   = pend_val_q[2:0];
                        rx_prog = 1'b1;
                    end
                end
                mtcc_pkg::SEL_RX_VAR: begin
                    vrate_d = pend_val_q[15:0];
                    rx_prog = 1'b1;
                end
                mtcc_pkg::SEL_RX_FREQ: begin
                    if (!freq_ok(pend_val_q)) rej_d = 1'b1;
                    else begin
                        rx_prog = 1'b1;
                        // During loopback the edit lands in the save copy
                        if (loop_q == mtcc_pkg::LB_NONE) dfreq_d = pend_val_q;
                        else save_d = pend_val_q;
                    end
                end
                mtcc_pkg::SEL_DESCR: begin
                    if (hide_descr) rej_d = 1'b1;
                    else descr_d = pend_val_q[0];
                end
                mtcc_pkg::SEL_RF_LOOP: begin
                    if (pend_val_q[0]) loop_d = mtcc_pkg::LB_RF;
                    else if (loop_q == mtcc_pkg::LB_RF)
                        loop_d = mtcc_pkg::LB_NONE;
                end
                mtcc_pkg::SEL_IF_LOOP: begin
                    if (pend_val_q[0]) loop_d = mtcc_pkg::LB_IF;
                    else if (loop_q == mtcc_pkg::LB_IF)
                        loop_d = mtcc_pkg::LB_NONE;
                end
                default: rej_d = 1'b1;
            endcase
        end
        // A new edit overrides whatever was still pending
        if (edit_valid_i) begin
            pend_vld_d = 1'b1;
            pend_sel_d = edit_sel_i;
            pend_val_d = edit_val_i;
        end
        if (rx_prog && rs_opt_i) rsd_d = mtcc_pkg::RSD_OFF;
        if (tx_reprog_i) rse_d = 1'b0;
        // Loopback entry saves, exit restores, while looped track tx freq
        if (loop_q == mtcc_pkg::LB_NONE && loop_d != mtcc_pkg::LB_NONE) begin
            save_d  = dfreq_q;
            dfreq_d = tx_freq_i;
        end else if (loop_q != mtcc_pkg::LB_NONE &&
                     loop_d == mtcc_pkg::LB_NONE) begin
            dfreq_d = save_q;
        end else if (loop_d != mtcc_pkg::LB_NONE) begin
            dfreq_d = tx_freq_i;
        end
        txoff_d = (rse_d != rse_q);
        rate_d  = preset_rate(pre_d, vrate_d);
        // Carrier test decode: {unmod, supp, upper, lower}
        case (car_d)
            mtcc_pkg::CAR_CENTER: begin
                cw_d  = 4'h8;
                div_d = 3'h0;
            end
            mtcc_pkg::CAR_DUAL: begin
                cw_d  = 4'h7;
                div_d = 3'h2;
            end
            mtcc_pkg::CAR_OFFSET: begin
                cw_d  = 4'h6;
                div_d = 3'h4;
            end
            default: begin
                cw_d  = 4'h0;
                div_d = 3'h0;
            end
        endcase
        // Descrambler {avail, enable, sync}; options follow straps
        dsc_d[2] = !hide_descr;
        dsc_d[0] = !hide_descr && rs_opt_i &&
                   (overhead_i == mtcc_pkg::OH_IDR) &&
                   (rsd_d == mtcc_pkg::RSD_ON);
        dsc_d[1] = !hide_descr && descr_d;
    end

    // Configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pend_vld_q <= 1'b0;
            pend_sel_q <= 4'h0;
            pend_val_q <= 21'h0;
            rej_q   <= 1'b0;
            txoff_q <= 1'b0;
            denc_q  <= mtcc_pkg::DIFF_ENC_RST;
            ddec_q  <= mtcc_pkg::DIFF_DEC_RST;
            car_q   <= mtcc_pkg::CAR_NORMAL;
            cw_q    <= 4'h0;
            div_q   <= 3'h0;
            mref_q  <= mtcc_pkg::MOD_REF_RST;
            sref_q  <= mtcc_pkg::SYN_REF_RST;
            rse_q   <= mtcc_pkg::RS_ENC_RST;
            rsd_q   <= mtcc_pkg::RSD_OFF;
            pre_q   <= mtcc_pkg::PRE_RST;
            vrate_q <= mtcc_pkg::RATE_V_KBPS;
            rate_q  <= mtcc_pkg::RATE_A_KBPS;
            descr_q <= mtcc_pkg::DESCR_RST;
            dsc_q   <= 3'h0;
            loop_q  <= mtcc_pkg::LB_NONE;
            dfreq_q <= mtcc_pkg::FREQ_RST;
            save_q  <= mtcc_pkg::FREQ_RST;
        end else begin
            pend_vld_q <= pend_vld_d;
            pend_sel_q <= pend_sel_d;
            pend_val_q <= pend_val_d;
            rej_q   <= rej_d;
            txoff_q <= txoff_d;
            denc_q  <= denc_d;
            ddec_q  <= ddec_d;
            car_q   <= car_d;
            cw_q    <= cw_d;
            div_q   <= div_d;
            mref_q  <= mref_d;
            sref_q  <= sref_d;
            rse_q   <= rse_d;
            rsd_q   <= rsd_d;
            pre_q   <= pre_d;
            vrate_q <= vrate_d;
            rate_q  <= rate_d;
            descr_q <= descr_d;
            dsc_q   <= dsc_d;
            loop_q  <= loop_d;
            dfreq_q <= dfreq_d;
            save_q  <= save_d;
        end
    end

    // Differential coders: mod-4 phase sum and difference
    logic [1:0] txp_q, txp_d, txo_q, txo_d, rxp_q, rxp_d, rxo_q, rxo_d;
    logic       txv_q, txv_d, rxv_q, rxv_d;
    always_comb begin
        txp_d = txp_q;
        txo_d = txo_q;
        rxp_d = rxp_q;
        rxo_d = rxo_q;
        txv_d = tx_sym_vld_i;
        rxv_d = rx_sym_vld_i;
        if (tx_sym_vld_i) begin
            txo_d = denc_q ? 2'(tx_sym_i + txp_q) : tx_sym_i;
            txp_d = txo_d;
        end
        if (rx_sym_vld_i) begin
            rxo_d = ddec_q ? 2'(rx_sym_i - rxp_q) : rx_sym_i;
            rxp_d = rx_sym_i;
        end
    end

    // Coder registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            txp_q <= 2'h0;
            txo_q <= 2'h0;
            rxp_q <= 2'h0;
            rxo_q <= 2'h0;
            txv_q <= 1'b0;
            rxv_q <= 1'b0;
        end else begin
            txp_q <= txp_d;
            txo_q <= txo_d;
            rxp_q <= rxp_d;
            rxo_q <= rxo_d;
            txv_q <= txv_d;
            rxv_q <= rxv_d;
        end
    end

    // Outputs from flops; loopback flags decoded from loop_q
    assign pend_valid_o   = pend_vld_q;
    assign reject_o       = rej_q;
    assign tx_out_off_o   = txoff_q;
    assign diff_enc_en_o  = denc_q;
    assign diff_dec_en_o  = ddec_q;
    assign carrier_mode_o = car_q;
    assign cw_unmod_o     = cw_q[3];
    assign cw_supp_o      = cw_q[2];
    assign sb_upper_o     = cw_q[1];
    assign sb_lower_o     = cw_q[0];
    assign sb_div_o       = div_q;
    assign mod_ref_sel_o  = mref_q;
    assign clock_synth_reference_select_o = sref_q;
    assign rs_enc_en_o    = rse_q;
    assign rs_dec_mode_o  = rsd_q;
    assign rx_preset_o    = pre_q;
    assign rx_rate_kbps_o = rate_q;
    assign descr_avail_o  = dsc_q[2];
    assign descr_en_o     = dsc_q[1];
    assign descr_sync_o   = dsc_q[0];
    assign rf_loop_o      = (loop_q == mtcc_pkg::LB_RF);
    assign if_loop_o      = (loop_q == mtcc_pkg::LB_IF);
    assign if_in_internal_o = (loop_q == mtcc_pkg::LB_IF);
    assign demod_freq_o   = dfreq_q;
    assign tx_sym_o       = txo_q;
    assign tx_sym_vld_o   = txv_q;
    assign rx_sym_o       = rxo_q;
    assign rx_sym_vld_o   = rxv_q;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    chk_loop_exclusive: assert property (
        execute_i && pend_vld_q && pend_sel_q == mtcc_pkg::SEL_RF_LOOP &&
        pend_val_q[0] |=> rf_loop_o && !if_loop_o)
        else $error("RF loopback did not cancel IF loopback");
    chk_enc_change_off: assert property (
        $changed(rs_enc_en_o) |-> tx_out_off_o)
        else $error("encoder change without tx off");
    chk_enc_reject: assert property (
        execute_i && pend_vld_q && pend_sel_q == mtcc_pkg::SEL_RS_ENC &&
        pend_val_q[0] && !qual |=> reject_o && $stable(rs_enc_en_o))
        else $error("unqualified encoder on not rejected");
    chk_txprog_clear: assert property (
        tx_reprog_i |=> !rs_enc_en_o) else $error("encoder kept on");
    chk_rxfreq_range: assert property (
        $changed(demod_freq_o) && $past(loop_q) == mtcc_pkg::LB_NONE &&
        loop_q == mtcc_pkg::LB_NONE |-> freq_ok(demod_freq_o))
        else $error("illegal receive frequency applied");
    chk_loop_tune: assert property (
        $rose(rf_loop_o) && $past(loop_q) == mtcc_pkg::LB_NONE
        |-> demod_freq_o == $past(tx_freq_i) && save_q == $past(dfreq_q))
        else $error("loopback entry tuning wrong");
    chk_loop_restore: assert property (
        loop_q != mtcc_pkg::LB_NONE && loop_d == mtcc_pkg::LB_NONE
        |=> demod_freq_o == $past(save_q))
        else $error("loopback exit restore wrong");
    chk_rx_clear_dec: assert property (
        execute_i && pend_vld_q && rs_opt_i &&
        pend_sel_q == mtcc_pkg::SEL_RX_PRE && pend_val_q[2:0] <= 3'h4
        |=> rs_dec_mode_o == mtcc_pkg::RSD_OFF)
        else $error("decoder not cleared");
    chk_pending_hold: assert property (
        !execute_i ##1 1'b1 |-> $stable(loop_q) && $stable(car_q))
        else $error("setting applied without execute");
    chk_descr_hidden: assert property (
        hide_descr |=> !descr_avail_o && !descr_en_o)
        else $error("descrambler visible for IBS or D&I");
    chk_dual_band: assert property (
        carrier_mode_o == mtcc_pkg::CAR_DUAL |->
        sb_div_o == 3'h2 && sb_upper_o && sb_lower_o && cw_supp_o)
        else $error("dual side-band setup wrong");

    cov_rf_to_if: cover property ($fell(rf_loop_o) && if_loop_o);
    cov_enc_reject: cover property (reject_o && !rs_enc_en_o);
    cov_offset_mode: cover property (carrier_mode_o == mtcc_pkg::CAR_OFFSET);
endmodule

// File: rtl/mtcc_pkg.sv
/*
 Constants, codes and reset values of the modem test and codec
 configuration controller. Assumes one system clock and a front-panel
 controller that presents edits as a select code plus a value.
*/
// Summary of operation
// - Transmit differential encoder enable, on or off, applied to symbols.
// - Carrier test mode: normal (default), center, dual or offset.
// - Center mode sends an unmodulated carrier at modulator frequency.
// - Dual mode: suppressed carrier, two side-bands at half symbol rate.
// - Offset mode: suppressed carrier, upper side-band at quarter rate.
// - High-stability option: mod reference internal 5 or ext 5/10/20 MHz.
// - That option: synthesizer reference is modulator or external input.
// - Any change of the encoder enable turns the transmitter off.
// - Encoder on is rejected when not qualified; old value kept, beep.
// - Transmit rate or frequency reprogram clears the encoder enable.
// - Receive presets A-D, variable; defaults 64/256/768/2048/128 kbps.
// - With the option, receive rate reprogram turns the decoder off.
// - Receive IF accepted only 50 to 180 MHz in 2.5 kHz steps.
// - With the option, receive frequency reprogram turns decoder off.
// - RS in IDR: V.35 descrambler unless decoder on, then synchronous.
// - Descrambler unavailable and hidden for IBS or D&I overhead.
// - Receive differential decoder enable, on or off, applied to symbols.
// - RF loopback on tunes demod to tx frequency; off restores it.
// - RF loopback on cancels IF loopback.
// - IF loopback routes output inside and retunes; off restores both.
// - IF loopback on cancels RF loopback.
// - Edits stay pending until the execute command applies them.
// - Decoder settings on, correction-off and off; off by default.
package mtcc_pkg;
    typedef enum logic [1:0] {
        CAR_NORMAL = 2'b00, CAR_CENTER = 2'b01,
        CAR_DUAL   = 2'b10, CAR_OFFSET = 2'b11
    } mtcc_car_e;
    typedef enum logic [1:0] {
        LB_NONE = 2'b00, LB_RF = 2'b01, LB_IF = 2'b10
    } mtcc_loop_e;
    typedef enum logic [1:0] {
        RSD_OFF = 2'b00, RSD_ON = 2'b01, RSD_NOCORR = 2'b10
    } mtcc_rsd_e;
    // Edit select codes
    localparam logic [3:0] SEL_DIFF_ENC = 4'h0;
    localparam logic [3:0] SEL_CARRIER  = 4'h1;
    localparam logic [3:0] SEL_MOD_REF  = 4'h2;
    localparam logic [3:0] SEL_SYN_REF  = 4'h3;
    localparam logic [3:0] SEL_RS_ENC   = 4'h4;
    localparam logic [3:0] SEL_RX_PRE   = 4'h5;
    localparam logic [3:0] SEL_RX_VAR   = 4'h6;
    localparam logic [3:0] SEL_RX_FREQ  = 4'h7;
    localparam logic [3:0] SEL_DESCR    = 4'h8;
    localparam logic [3:0] SEL_DIFF_DEC = 4'h9;
    localparam logic [3:0] SEL_RF_LOOP  = 4'hA;
    localparam logic [3:0] SEL_IF_LOOP  = 4'hB;
    localparam logic [3:0] SEL_RS_DEC   = 4'hC;
    // Overhead type codes
    localparam logic [1:0] OH_IDR = 2'h0;
    localparam logic [1:0] OH_IBS = 2'h1;
    localparam logic [1:0] OH_DI  = 2'h2;
    // Modulator reference codes
    localparam logic [1:0] MREF_INT5  = 2'h0;
    localparam logic [1:0] MREF_EXT5  = 2'h1;
    localparam logic [1:0] MREF_EXT10 = 2'h2;
    localparam logic [1:0] MREF_EXT20 = 2'h3;
    // Receive presets, A to D then variable
    localparam logic [2:0] PRE_A = 3'h0;
    localparam logic [2:0] PRE_B = 3'h1;
    localparam logic [2:0] PRE_C = 3'h2;
    localparam logic [2:0] PRE_D = 3'h3;
    localparam logic [2:0] PRE_V = 3'h4;
    localparam logic [15:0] RATE_A_KBPS = 16'h0040;
    localparam logic [15:0] RATE_B_KBPS = 16'h0100;
    localparam logic [15:0] RATE_C_KBPS = 16'h0300;
    localparam logic [15:0] RATE_D_KBPS = 16'h0800;
    localparam logic [15:0] RATE_V_KBPS = 16'h0080;
    // Frequencies in 100 Hz units
    localparam int FREQ_W = 21;
    localparam logic [20:0] FREQ_MIN  = 21'h07A120;
    localparam logic [20:0] FREQ_MAX  = 21'h1B7740;
    localparam logic [20:0] FREQ_STEP = 21'h000019;
    localparam logic [20:0] FREQ_RST  = 21'h0AAE60;
    // Reset values
    localparam logic       DIFF_ENC_RST = 1'h1;
    localparam logic       DIFF_DEC_RST = 1'h1;
    localparam logic       DESCR_RST    = 1'h1;
    localparam logic       RS_ENC_RST   = 1'h0;
    localparam logic       SYN_REF_RST  = 1'h0;
    localparam logic [1:0] MOD_REF_RST  = 2'h0;
    localparam logic [2:0] PRE_RST      = 3'h0;
endpackage

// File: verification/mtcc_panel.sv
/*
 Front-panel keypad model: presents one edit, then the execute key.
 Assumes it is called from the bench at a falling clock edge.
*/
`timescale 1ns/100ps
module mtcc_panel (
    input  wire logic        clk_sys_i,
    output logic             edit_valid_o,
    output logic [3:0]       edit_sel_o,
    output logic [20:0]      edit_val_o,
    output logic             execute_o
);
    // Keys idle until the operator acts
    initial begin
        edit_valid_o = 1'h0;
        edit_sel_o   = 4'h0;
        edit_val_o   = 21'h000000;
        execute_o    = 1'h0;
    end
    // One-cycle edit pulse; the value is left pending
    task automatic edit(input logic [3:0] s, input logic [20:0] v);
        @(negedge clk_sys_i);
        edit_valid_o = 1'h1;
        edit_sel_o   = s;
        edit_val_o   = v;
        @(negedge clk_sys_i);
        edit_valid_o = 1'h0;
    endtask
    // Execute commits the pending edit, kept apart from edit on purpose
    task automatic exec();
        execute_o = 1'h1;
        @(negedge clk_sys_i);
        execute_o = 1'h0;
    endtask
endmodule

// File: verification/modem_test_and_codec_config_ctrl_test.sv
/*
 Self-checking bench of the configuration and interlock controller.
 Assumes the keypad model mtcc_panel and settings seen one cycle late.
*/
`timescale 1ns/100ps
module modem_test_and_codec_config_ctrl_test;
    logic clk_sys_i = 1'h0, rst_n_i = 1'h0, edit_valid_i, execute_i;
    logic rs_opt_i = 1'h1, hstab_opt_i = 1'h1, rs_qualify_i = 1'h0;
    logic tx_reprog_i = 1'h0, tx_sym_vld_i = 1'h0, rx_sym_vld_i = 1'h0;
    logic [1:0] overhead_i = 2'h0, tx_sym_i = 2'h0, rx_sym_i = 2'h0;
    logic [3:0] edit_sel_i;
    logic [20:0] edit_val_i, tx_freq_i = 21'h0C3500;
    logic pend_valid_o, reject_o, tx_out_off_o, diff_enc_en_o, cw_unmod_o;
    logic cw_supp_o, sb_upper_o, sb_lower_o, rs_enc_en_o, descr_avail_o;
    logic clock_synth_reference_select_o, descr_en_o, descr_sync_o;
    logic diff_dec_en_o, rf_loop_o, if_loop_o, if_in_internal_o;
    logic tx_sym_vld_o, rx_sym_vld_o;
    logic [1:0] carrier_mode_o, mod_ref_sel_o, rs_dec_mode_o, tx_sym_o;
    logic [1:0] rx_sym_o;
    logic [2:0] sb_div_o, rx_preset_o;
    logic [15:0] rx_rate_kbps_o;
    logic [20:0] demod_freq_o;
    int num_errors = 0, total_checks = 0;
    // Clock of 25 ns
    always #12.5 clk_sys_i = ~clk_sys_i;
    mtcc_panel panel (.clk_sys_i, .edit_valid_o(edit_valid_i),
        .edit_sel_o(edit_sel_i), .edit_val_o(edit_val_i),
        .execute_o(execute_i));
    mtcc_ctrl uut (.clk_sys_i, .rst_n_i, .edit_valid_i, .edit_sel_i,
        .edit_val_i, .execute_i, .rs_opt_i, .hstab_opt_i, .rs_qualify_i,
        .overhead_i, .tx_reprog_i, .tx_freq_i, .tx_sym_i, .tx_sym_vld_i,
        .rx_sym_i, .rx_sym_vld_i, .pend_valid_o, .reject_o, .tx_out_off_o,
        .diff_enc_en_o, .carrier_mode_o, .cw_unmod_o, .cw_supp_o,
        .sb_upper_o, .sb_lower_o, .sb_div_o, .mod_ref_sel_o,
        .clock_synth_reference_select_o, .rs_enc_en_o, .rx_preset_o,
        .rx_rate_kbps_o, .rs_dec_mode_o, .descr_avail_o, .descr_en_o,
        .descr_sync_o, .diff_dec_en_o, .rf_loop_o, .if_loop_o,
        .if_in_internal_o, .demod_freq_o, .tx_sym_o, .tx_sym_vld_o,
        .rx_sym_o, .rx_sym_vld_o);
    // Compare and count; four-state so an unknown matches only an unknown
    task automatic chk(input logic [20:0] s, input logic [20:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic press(input logic [3:0] s, input logic [20:0] v);
        panel.edit(s, v);
        panel.exec();
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic t_reset();
        chk(carrier_mode_o, 21'h0); chk(rs_enc_en_o, 21'h0);
        chk(rf_loop_o | if_loop_o, 21'h0); chk(rs_dec_mode_o, 21'h0);
        chk(rx_rate_kbps_o, 21'h40); chk(demod_freq_o, 21'h0AAE60);
    endtask
    // Every carrier mode and reference code, side-band outputs too
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            press(mtcc_pkg::SEL_CARRIER, 21'(i));
            chk(carrier_mode_o, 21'(i)); chk(cw_unmod_o, 21'(i == 1));
            chk(cw_supp_o, 21'(i > 1)); chk(sb_upper_o, 21'(i > 1));
            chk(sb_lower_o, 21'(i == 2));
            chk(sb_div_o, 21'(i == 2 ? 2 : (i == 3 ? 4 : 0)));
            press(mtcc_pkg::SEL_MOD_REF, 21'(3 - i));
            chk(mod_ref_sel_o, 21'(3 - i));
        end
        press(mtcc_pkg::SEL_SYN_REF, 21'h1);
        chk(clock_synth_reference_select_o, 21'h1);
    endtask
    // One-cycle symbol strobe on both coders
    task automatic sym_pulse();
        tx_sym_vld_i = 1'h1;
        rx_sym_vld_i = 1'h1;
        @(negedge clk_sys_i);
        tx_sym_vld_i = 1'h0;
        rx_sym_vld_i = 1'h0;
    endtask
    // Edit held pending; encoder bypass then sum of previous output
    task automatic t_pend_enc();
        panel.edit(mtcc_pkg::SEL_DIFF_ENC, 21'h0);
        chk(pend_valid_o, 21'h1); chk(diff_enc_en_o, 21'h1);
        panel.exec();
        chk(diff_enc_en_o, 21'h0); chk(pend_valid_o, 21'h0);
        tx_sym_i = 2'h1;
        rx_sym_i = 2'h3;
        sym_pulse();
        chk(tx_sym_o, 21'h1); chk(rx_sym_o, 21'h3);
        chk(tx_sym_vld_o, 21'h1); chk(rx_sym_vld_o, 21'h1);
        press(mtcc_pkg::SEL_DIFF_ENC, 21'h1);
        rx_sym_i = 2'h1;
        sym_pulse();
        chk(tx_sym_o, 21'h2); chk(rx_sym_o, 21'h2);
        press(mtcc_pkg::SEL_DIFF_DEC, 21'h0);
        chk(diff_dec_en_o, 21'h0); chk(tx_sym_vld_o, 21'h0);
        rx_sym_i = 2'h2;
        sym_pulse();
        chk(rx_sym_o, 21'h2); chk(tx_sym_o, 21'h3);
    endtask
    // Encoder on refused, accepted, then cleared by a tx reprogram
    task automatic t_rs_enc();
        press(mtcc_pkg::SEL_RS_ENC, 21'h1);
        chk(reject_o, 21'h1); chk(rs_enc_en_o, 21'h0);
        rs_qualify_i = 1'h1;
        press(mtcc_pkg::SEL_RS_ENC, 21'h1);
        chk(rs_enc_en_o, 21'h1); chk(tx_out_off_o, 21'h1);
        tx_reprog_i = 1'h1;
        @(negedge clk_sys_i);
        tx_reprog_i = 1'h0;
        chk(rs_enc_en_o, 21'h0); chk(tx_out_off_o, 21'h1);
    endtask
    // Receive frequency upper bound and step grid, decoder clears, descrambler choice
    task automatic t_rx();
        press(mtcc_pkg::SEL_RS_DEC, 21'h1);
        chk(rs_dec_mode_o, 21'h1);
        @(negedge clk_sys_i);
        chk(descr_sync_o, 21'h1);
        press(mtcc_pkg::SEL_RX_FREQ, mtcc_pkg::FREQ_MAX + 21'h19);
        chk(reject_o, 21'h1);
        press(mtcc_pkg::SEL_RX_FREQ, mtcc_pkg::FREQ_MIN + 21'h1);
        chk(reject_o, 21'h1);
        press(mtcc_pkg::SEL_RX_FREQ, mtcc_pkg::FREQ_MAX);
        chk(demod_freq_o, mtcc_pkg::FREQ_MAX); chk(rs_dec_mode_o, 21'h0);
        press(mtcc_pkg::SEL_RS_DEC, 21'h1);
        press(mtcc_pkg::SEL_RX_PRE, 21'(mtcc_pkg::PRE_D));
        chk(rx_rate_kbps_o, 21'h800); chk(rs_dec_mode_o, 21'h0);
        chk(rx_preset_o, 21'h3); chk(descr_en_o, 21'h1);
        press(mtcc_pkg::SEL_RX_PRE, 21'(mtcc_pkg::PRE_V));
        chk(rx_rate_kbps_o, 21'h80);
        press(mtcc_pkg::SEL_RX_VAR, 21'h0200);
        chk(rx_rate_kbps_o, 21'h200); chk(rx_preset_o, 21'h4);
        press(mtcc_pkg::SEL_RS_DEC, 21'h2);
        chk(rs_dec_mode_o, 21'h2); chk(descr_sync_o, 21'h0);
        overhead_i = mtcc_pkg::OH_IBS;
        repeat (2) @(negedge clk_sys_i);
        chk(descr_avail_o, 21'h0); chk(descr_en_o, 21'h0);
        press(mtcc_pkg::SEL_DESCR, 21'h0);
        chk(reject_o, 21'h1);
    endtask
    // IF to RF switch keeps the saved frequency for the restore
    task automatic t_loop();
        press(mtcc_pkg::SEL_RF_LOOP, 21'h1);
        chk(rf_loop_o, 21'h1); chk(demod_freq_o, tx_freq_i);
        press(mtcc_pkg::SEL_IF_LOOP, 21'h1);
        chk(rf_loop_o, 21'h0); chk(if_in_internal_o, 21'h1);
        press(mtcc_pkg::SEL_RX_FREQ, mtcc_pkg::FREQ_MIN);
        chk(demod_freq_o, tx_freq_i);
        press(mtcc_pkg::SEL_RF_LOOP, 21'h1);
        chk(if_loop_o, 21'h0);
        press(mtcc_pkg::SEL_RF_LOOP, 21'h0);
        chk(demod_freq_o, mtcc_pkg::FREQ_MIN);
        chk(if_in_internal_o, 21'h0);
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        num_errors++;
        print_verdict();
    end
    // Main sequence: reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'h1;
        t_reset();
        t_modes();
        t_pend_enc();
        t_rs_enc();
        t_rx();
        t_loop();
        print_verdict();
    end
endmodule
